// ### include/apc_defines.svh
`ifndef APC_DEFINES_SVH
`define APC_DEFINES_SVH

// ****************************************************************
// Register map, byte addresses on the APB.
// ****************************************************************
`define APC_ADDR_W 12
`define APC_OFS_CTRL 12'h000
`define APC_OFS_STATUS 12'h004
`define APC_OFS_POS 12'h008
`define APC_OFS_REFUSED 12'h00c

// ****************************************************************
// Control register fields and reset value.
// ****************************************************************
`define APC_CTRL_RUN 0
`define APC_CTRL_SWREQ 1
`define APC_CTRL_QUAD 2
`define APC_CTRL_RESET 32'h0000_0005

// ****************************************************************
// Status register fields.
// ****************************************************************
`define APC_STAT_ABS 0
`define APC_STAT_GRAY 1
`define APC_STAT_POLINST 2
`define APC_STAT_BUSY 3
`define APC_STAT_BUFVALID 4
`define APC_STAT_BUFREADY 5

// ****************************************************************
// Timing: clock period and serial half bit time.
// ****************************************************************
`define APC_CLK_NS 40
`define APC_SER_HALF_NS 400
`define APC_SER_HALF_CYC ((`APC_SER_HALF_NS + `APC_CLK_NS - 1) / `APC_CLK_NS)

`endif

// ### include/apc_pkg.sv
package apc_pkg;

  // Strap settings as read from the board jumpers; one means installed.
  typedef struct packed {
    logic encFamily;  // Installed turns absolute mode and quadrature off.
    logic codeFormat; // Installed selects Gray input data.
    logic polarity;   // Installed adds the extra inversion.
  } apc_straps_t;

  // Pseudo quadrature output group.
  typedef struct packed {
    logic a;    // Phase A.
    logic b;    // Phase B.
    logic zero; // Zero position marker.
  } apc_quad_t;

  // Serializer states.
  typedef enum logic {
    SER_IDLE,
    SER_SHIFT
  } apc_ser_state_t;

endpackage : apc_pkg

// ### logic/apc_buffer.sv
`timescale 1ns/1ns
// ****************************************************************
// Small shift-register buffer; the head entry is a register, so the
// read data always comes straight from a flip-flop.
// ****************************************************************
module apc_buffer #(
  parameter int WIDTH = 12, // Word width.
  parameter int DEPTH = 2   // Number of entries.
) (
  input wire logic clk,               // System clock.
  input wire logic rst_n,             // Asynchronous reset, active low.
  input wire logic inValid,           // Writer offers a word.
  output logic inReady,               // Buffer has room.
  input wire logic [WIDTH-1:0] inData, // Word being written.
  output logic outValid,              // Head entry holds a word.
  input wire logic outReady,          // Reader takes the head word.
  output logic [WIDTH-1:0] outData    // Head word.
);

  logic [WIDTH-1:0] entry [DEPTH];   // Storage, entry zero is the head.
  logic [DEPTH:0] fill;              // Number of words held.
  logic push;                        // Word accepted this cycle.
  logic pop;                         // Word removed this cycle.

  assign inReady = (fill < (DEPTH + 1)'(DEPTH));
  assign outValid = (fill != '0);
  assign outData = entry[0];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // Fill level; a push and a pop together leave it unchanged.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fill <= '0;
    end else if (push && !pop) begin
      fill <= fill + 1'b1;
    end else if (pop && !push) begin
      fill <= fill - 1'b1;
    end
  end

  // Entries below the last shift toward the head on a pop; a push loads the first free entry.
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          entry[i] <= '0;
        end else if (push && ((pop ? fill - 1'b1 : fill) == (DEPTH + 1)'(i))) begin
          entry[i] <= inData;
        end else if (pop && (i < DEPTH - 1)) begin
          entry[i] <= entry[(i < DEPTH - 1) ? i + 1 : i];
        end
      end
    end
  endgenerate

endmodule : apc_buffer

// ### logic/apc_conditioner.sv
`timescale 1ns/1ns
`include "apc_defines.svh"
// Summary of operation
// - Absolute mode whenever family strap is removed.
// - Straps pick Gray/binary and high/low true.
// - Gray low true: invert, then convert.
// - Binary low true: invert only.
// - Gray high true: convert only.
// - Binary high true: pass word unchanged.
// - Shift word out only on processor request.
// - Pseudo quadrature A, B, zero from position.
// - Input stage inverts every encoder bit.
// - Installed polarity strap adds second inversion.
// - Reversed mounting corrected by flipping polarity strap.
// - Position taken from twelve single ended inputs.
module apc_conditioner #(
  parameter int POS_W = 12,                        // Position inputs.
  parameter int HALF_CYC = `APC_SER_HALF_CYC,      // Cycles per half bit.
  parameter int BUF_DEPTH = 2                      // Buffer entries.
) (
  input wire logic clk,                            // System clock.
  input wire logic rst_n,                          // Asynchronous reset.
  input wire logic psel,                           // APB select.
  input wire logic penable,                        // APB access phase.
  input wire logic pwrite,                         // APB direction.
  input wire logic [`APC_ADDR_W-1:0] paddr,        // APB byte address.
  input wire logic [31:0] pwdata,                  // APB write data.
  output logic [31:0] prdata,                      // APB read data.
  output logic pready,                             // APB ready.
  output logic pslverr,                            // APB error.
  input wire logic [POS_W-1:0] encLines,           // Encoder pin levels.
  input wire apc_pkg::apc_straps_t straps,         // Jumper levels.
  input wire logic xferReq,                        // Processor request.
  input wire logic serHold,                        // Receiver stall.
  output logic serClk,                             // Serial clock.
  output logic serData,                            // Serial data, MSB first.
  output logic serFrame,                           // High during a word.
  output apc_pkg::apc_quad_t quad,                 // Pseudo quadrature.
  output logic absMode                             // Absolute mode active.
);

  // ****************************************************************
  // Helper functions.
  // ****************************************************************

  // Gray to binary, the top bit kept and each lower bit chained.
  function automatic logic [POS_W-1:0] grayToBin(input logic [POS_W-1:0] g);
    logic [POS_W-1:0] b;
    b = '0;
    b[POS_W-1] = g[POS_W-1];
    for (int k = POS_W - 2; k >= 0; k--) begin
      b[k] = b[k+1] ^ g[k];
    end
    return b;
  endfunction : grayToBin

  // Address decode, shared by the registered read data and the error answer.
  function automatic logic regHit(input logic [`APC_ADDR_W-1:0] a);
    return (a == `APC_OFS_CTRL) || (a == `APC_OFS_STATUS) ||
           (a == `APC_OFS_POS) || (a == `APC_OFS_REFUSED);
  endfunction : regHit

  // ****************************************************************
  // Input synchronisers.
  // ****************************************************************

  logic [POS_W-1:0] encS1, encS2, encS3; // Position synchroniser stages.
  logic [2:0] strS1, strS2, strS3;       // Strap synchroniser stages.
  logic [1:0] ctlS1, ctlS2, ctlS3;       // Request and hold stages.
  logic [POS_W-1:0] encStable;           // Last agreed position word.
  apc_pkg::apc_straps_t strStable;       // Last agreed straps.
  logic holdStable;                      // Agreed stall level.

  // Three stages each; the first only feeds the second.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      encS1 <= '0;
      encS2 <= '0;
      encS3 <= '0;
      strS1 <= '0;
      strS2 <= '0;
      strS3 <= '0;
      ctlS1 <= '0;
      ctlS2 <= '0;
      ctlS3 <= '0;
    end else begin
      encS1 <= encLines;
      encS2 <= encS1;
      encS3 <= encS2;
      strS1 <= straps;
      strS2 <= strS1;
      strS3 <= strS2;
      ctlS1 <= {serHold, xferReq};
      ctlS2 <= ctlS1;
      ctlS3 <= ctlS2;
    end
  end

  // A change counts only once the second and third stages agree.
  // This also rejects a word caught mid transition on the pins.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      encStable <= '0;
      strStable <= '0;
      holdStable <= 1'b0;
    end else begin
      if (encS2 == encS3) begin
        encStable <= encS2;
      end
      if (strS2 == strS3) begin
        strStable <= strS2;
      end
      if (ctlS2[1] == ctlS3[1]) begin
        holdStable <= ctlS2[1];
      end
    end
  end

  // Request edge: the second and third stages agree on a new high.
  logic hwReqEdge; // One cycle on a rising request.
  logic reqSeen;   // Request level already counted.
  assign hwReqEdge = ctlS2[0] && ctlS3[0] && !reqSeen;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reqSeen <= 1'b0;
    end else if (ctlS2[0] == ctlS3[0]) begin
      reqSeen <= ctlS2[0];
    end
  end

  // ****************************************************************
  // Word conditioning.
  // ****************************************************************

  logic [POS_W-1:0] optoWord;   // Word after the optocoupler stage.
  logic [POS_W-1:0] polWord;    // Word after the polarity stage.
  logic [POS_W-1:0] condWord;   // Binary position.
  logic [POS_W-1:0] position;   // Registered binary position.

  // The input stage inverts every line.
  assign optoWord = ~encStable;
  // Installed polarity strap undoes it for high true encoders; removed
  // leaves low true data inverted. Flipping the strap also corrects a
  // reversed mounting.
  assign polWord = strStable.polarity ? ~optoWord : optoWord;
  // Gray data is decoded after the polarity stage; binary is not.
  assign condWord = strStable.codeFormat ? grayToBin(polWord) : polWord;

  // Absolute mode whenever the family strap is removed.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      absMode <= 1'b0;
      position <= '0;
    end else begin
      absMode <= !strStable.encFamily;
      position <= condWord;
    end
  end

  // ****************************************************************
  // Register file over APB.
  // ****************************************************************

  logic [31:0] ctrl;            // Control register.
  logic [31:0] refused;         // Requests lost to a full buffer.
  logic [31:0] readWord;        // Read mux output.
  logic apbWrite;               // Write takes effect this edge.
  logic swReq;                  // Software request pulse.
  logic bufInReady;             // Buffer has room.
  logic bufOutValid;            // Buffer holds a word.
  logic [POS_W-1:0] bufOutData; // Head word of the buffer.
  apc_pkg::apc_ser_state_t serState; // Serializer state.

  assign apbWrite = psel && penable && pready && pwrite;

  // Read mux; reserved bits read as zero.
  always_comb begin
    readWord = '0;
    case (paddr)
      `APC_OFS_CTRL: begin
        readWord = ctrl;
      end
      `APC_OFS_STATUS: begin
        readWord[`APC_STAT_ABS] = absMode;
        readWord[`APC_STAT_GRAY] = strStable.codeFormat;
        readWord[`APC_STAT_POLINST] = strStable.polarity;
        readWord[`APC_STAT_BUSY] = (serState == apc_pkg::SER_SHIFT);
        readWord[`APC_STAT_BUFVALID] = bufOutValid;
        readWord[`APC_STAT_BUFREADY] = bufInReady;
      end
      `APC_OFS_POS: begin
        readWord[POS_W-1:0] = position;
      end
      `APC_OFS_REFUSED: begin
        readWord = refused;
      end
      default: begin
        readWord = '0;
      end
    endcase
  end

  // One wait state, so that ready and read data both leave flip-flops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !regHit(paddr);
      prdata <= (pwrite || !regHit(paddr)) ? 32'h0000_0000 : readWord;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Control register; the request bit is a strobe and never stored.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `APC_CTRL_RESET;
      swReq <= 1'b0;
    end else begin
      swReq <= apbWrite && (paddr == `APC_OFS_CTRL) && pwdata[`APC_CTRL_SWREQ];
      if (apbWrite && (paddr == `APC_OFS_CTRL)) begin
        ctrl <= pwdata & 32'h0000_0005;
      end
    end
  end

  // ****************************************************************
  // Request capture into the buffer.
  // ****************************************************************

  logic reqTake; // A request that may start a transfer.
  assign reqTake = (hwReqEdge || swReq) && absMode && ctrl[`APC_CTRL_RUN];

  // Refused count; a refusal in the clearing cycle still counts.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refused <= '0;
    end else if (reqTake && !bufInReady) begin
      refused <= (apbWrite && (paddr == `APC_OFS_REFUSED)) ? 32'h0000_0001 : refused + 1'b1;
    end else if (apbWrite && (paddr == `APC_OFS_REFUSED)) begin
      refused <= '0;
    end
  end

  logic serPop; // Serializer takes the head word.
  assign serPop = (serState == apc_pkg::SER_IDLE);

  apc_buffer #(
    .WIDTH(POS_W),
    .DEPTH(BUF_DEPTH)
  ) u_buffer (
    .clk(clk),
    .rst_n(rst_n),
    .inValid(reqTake),
    .inReady(bufInReady),
    .inData(position),
    .outValid(bufOutValid),
    .outReady(serPop),
    .outData(bufOutData)
  );

  // ****************************************************************
  // Serializer.
  // ****************************************************************

  logic [POS_W-1:0] shiftReg; // Bits still to send, next at the top.
  logic [4:0] bitsLeft;       // Bits remaining in the word.
  logic [15:0] halfCnt;       // Half bit timer.
  logic halfTick;             // Half bit elapsed.

  // A stall only holds the line between bits, with the clock low.
  assign halfTick = (halfCnt == 16'(HALF_CYC - 1)) && !(holdStable && !serClk);

  // Half bit timer runs only while a word is on the line.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      halfCnt <= '0;
    end else if (serState != apc_pkg::SER_SHIFT || halfTick) begin
      halfCnt <= '0;
    end else if (halfCnt != 16'(HALF_CYC - 1)) begin
      halfCnt <= halfCnt + 1'b1;
    end
  end

  // Data changes with the falling clock; the receiver samples on rise.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serState <= apc_pkg::SER_IDLE;
      shiftReg <= '0;
      bitsLeft <= '0;
      serClk <= 1'b0;
      serData <= 1'b0;
      serFrame <= 1'b0;
    end else begin
      case (serState)
        apc_pkg::SER_IDLE: begin
          serClk <= 1'b0;
          if (bufOutValid) begin
            shiftReg <= bufOutData << 1;
            serData <= bufOutData[POS_W-1];
            bitsLeft <= 5'(POS_W);
            serFrame <= 1'b1;
            serState <= apc_pkg::SER_SHIFT;
          end else begin
            serFrame <= 1'b0;
            serData <= 1'b0;
          end
        end
        apc_pkg::SER_SHIFT: begin
          if (halfTick && !serClk) begin
            serClk <= 1'b1;
          end else if (halfTick) begin
            serClk <= 1'b0;
            if (bitsLeft == 5'd1) begin
              serFrame <= 1'b0;
              serData <= 1'b0;
              serState <= apc_pkg::SER_IDLE;
            end else begin
              serData <= shiftReg[POS_W-1];
              shiftReg <= shiftReg << 1;
              bitsLeft <= bitsLeft - 1'b1;
            end
          end
        end
        default: begin
          serState <= apc_pkg::SER_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Pseudo quadrature from the binary position.
  // ****************************************************************

  // Two low bits walk the four quadrature states; zero marks count 0.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quad <= '0;
    end else if (absMode && ctrl[`APC_CTRL_QUAD]) begin
      quad.a <= position[1];
      quad.b <= position[1] ^ position[0];
      quad.zero <= (position == '0);
    end else begin
      quad <= '0;
    end
  end

endmodule : apc_conditioner

// ### tb/apc_conditioner_props.sv
`timescale 1ns/1ns
// ****************************************************************
// Port checks for the conditioner: bus timing, mode and serial line.
// ****************************************************************
module apc_conditioner_props #(
  parameter int HALF_CYC = 10 // Cycles per half bit.
) (
  input wire logic clk,                    // System clock.
  input wire logic rst_n,                  // Asynchronous reset.
  input wire logic psel,                   // APB select.
  input wire logic penable,                // APB access phase.
  input wire logic pready,                 // APB ready.
  input wire logic pslverr,                // APB error.
  input wire apc_pkg::apc_straps_t straps, // Jumper levels.
  input wire logic absMode,                // Absolute mode active.
  input wire logic serClk,                 // Serial clock.
  input wire logic serData,                // Serial data.
  input wire logic serFrame,               // Word frame.
  input wire apc_pkg::apc_quad_t quad      // Pseudo quadrature.
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  int hiCnt; // High cycles of the serial clock so far.

  // Counts the high phase so that its length can be judged at the fall.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hiCnt <= 0;
    end else begin
      hiCnt <= serClk ? hiCnt + 1 : 0;
    end
  end

  // The straps pass a synchroniser, so they must settle before the mode follows.
  abs_mode_on_a: assert property (!straps.encFamily [*8] |-> absMode)
    else $error("absolute mode missing with family strap removed");
  abs_mode_off_a: assert property (straps.encFamily [*8] |-> !absMode && quad == 3'h0)
    else $error("absolute mode or quadrature active with family strap installed");
  quad_zero_a: assert property (quad.zero |-> !quad.a && !quad.b)
    else $error("zero marker with phases not at zero");
  clk_idle_a: assert property (!serFrame |-> !serClk)
    else $error("serial clock high outside a frame");
  half_bit_a: assert property ($fell(serClk) |-> hiCnt == HALF_CYC)
    else $error("serial clock high phase has wrong length");
  data_hold_a: assert property (serClk |-> $stable(serData))
    else $error("serial data moved while clock high");
  frame_end_a: assert property ($fell(serFrame) |-> $past(serClk) && !serClk)
    else $error("frame ended away from a falling serial clock");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  pready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("ready not given after one wait state");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule : apc_conditioner_props

bind apc_conditioner apc_conditioner_props #(.HALF_CYC(HALF_CYC)) props_i (.clk, .rst_n,
  .psel, .penable, .pready, .pslverr, .straps, .absMode, .serClk, .serData, .serFrame, .quad);

// ### tb/apc_encoder_model.sv
`timescale 1ns/1ns
// ****************************************************************
// Far side: an absolute encoder and the requesting processor.
// ****************************************************************
module apc_encoder_model (
  input wire logic clk,             // System clock.
  input wire logic [11:0] position, // Shaft position, natural binary.
  input wire logic grayOut,         // Encoder emits Gray code.
  input wire logic lowTrue,         // Encoder drives low true levels.
  input wire logic ask,             // Bench asks for a transfer.
  input wire logic serClk,          // Serial clock from the block.
  input wire logic serData,         // Serial data from the block.
  input wire logic serFrame,        // Frame from the block.
  output logic [11:0] encLines,     // Twelve single ended position lines.
  output logic xferReq,             // Transfer request.
  output logic [11:0] rxWord,       // Last word received.
  output logic [7:0] rxCount = 8'h0 // Words received.
);
  logic [11:0] code;           // Position in the chosen code.
  logic [11:0] shiftReg;       // Bits gathered in the frame.
  logic prevClk = 1'h0;        // Serial clock one cycle ago.
  logic prevFrame = 1'h0;      // Frame one cycle ago.
  int reqCnt = 0;              // Cycles the request stays high.

  // A low true encoder drives the complement, so zero shows as all ones.
  always_comb begin
    code = grayOut ? (position ^ (position >> 1)) : position;
    encLines = lowTrue ? ~code : code;
  end

  // The request is held for several cycles so the synchroniser sees it.
  always @(posedge clk) begin
    reqCnt <= ask ? 6 : (reqCnt > 0 ? reqCnt - 1 : 0);
    xferReq <= ask || reqCnt > 1;
  end

  // Bits are taken at the rising serial clock; the word closes with the frame.
  always @(posedge clk) begin
    prevClk <= serClk;
    prevFrame <= serFrame;
    if (serClk && !prevClk && serFrame) begin
      shiftReg <= {shiftReg[10:0], serData};
    end
    if (!serFrame && prevFrame) begin
      rxWord <= shiftReg;
      rxCount <= rxCount + 8'h1;
    end
  end
endmodule : apc_encoder_model

// ### tb/apc_conditioner_tb.sv
`timescale 1ns/1ns
`include "apc_defines.svh"
// ****************************************************************
// Bench: register reads, strap combinations and serial transfers.
// ****************************************************************
module apc_conditioner_tb;
  localparam int HALF = 2;      // Shortened half bit keeps the run short.
  localparam int LIMIT = 30000; // Cycle ceiling for the whole run.
  logic clk;
  logic rst_n;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] encLines, position, rxWord, e;
  apc_pkg::apc_straps_t straps;
  apc_pkg::apc_quad_t quad;
  logic xferReq, serHold, serClk, serData, serFrame, absMode, grayOut, lowTrue, ask, err;
  logic [7:0] rxCount;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;

  apc_conditioner #(.HALF_CYC(HALF)) uut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .encLines, .straps, .xferReq, .serHold, .serClk,
    .serData, .serFrame, .quad, .absMode);
  apc_encoder_model model (.clk, .position, .grayOut, .lowTrue, .ask, .serClk, .serData,
    .serFrame, .encLines, .xferReq, .rxWord, .rxCount);

  // Free running 25 MHz clock.
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // A hang is cut short and counted as a mismatch.
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      give_verdict();
    end
  end

  // Compares one value and reports a mismatch at once.
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One APB transfer; an idle cycle follows so requests never collide.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb

  // Waits for the processor side to have taken a number of words.
  // A word that never arrives is caught by the cycle ceiling.
  task wait_rx(input logic [7:0] target);
    while (rxCount !== target) @(posedge clk);
  endtask : wait_rx

  // Expected word: pin level, input inversion, strap inversion, then Gray decode.
  function automatic logic [11:0] cond(input logic [11:0] p, input logic g, input logic lt,
                                       input logic pol);
    logic [11:0] w;
    w = g ? (p ^ (p >> 1)) : p;
    w = lt ? ~w : w;
    w = pol ? w : ~w;
    if (g) for (int k = 10; k >= 0; k--) w[k] = w[k+1] ^ w[k];
    return w;
  endfunction : cond

  // Prints the counts and the verdict, then stops.
  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  initial begin
    rst_n = 1'h0;
    {psel, penable, pwrite, ask, serHold, grayOut, lowTrue} = 7'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    position = 12'h0;
    straps = 3'h1;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    apb(1'h0, `APC_OFS_CTRL, 32'h0);
    check("control reset", 32'h5, rd);
    apb(1'h0, 12'h010, 32'h0);
    check("unmapped error", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rd);
    // Every code, encoder polarity, strap polarity and two positions.
    for (int i = 0; i < 16; i++) begin
      grayOut <= i[0];
      lowTrue <= i[1];
      straps <= {1'h0, i[0], i[2]};
      position <= i[3] ? 12'h5a3 : 12'h000;
      e = cond(i[3] ? 12'h5a3 : 12'h000, i[0], i[1], i[2]);
      repeat (10) @(posedge clk);
      if (i == 2) check("low true zero", 32'hfff, {20'h0, encLines});
      apb(1'h0, `APC_OFS_POS, 32'h0);
      check("position word", {20'h0, e}, rd);
      apb(1'h0, `APC_OFS_STATUS, 32'h0);
      check("strap status", {29'h0, i[2], i[0], 1'h1}, rd & 32'h7);
      check("pseudo quadrature", {29'h0, e[1], e[1] ^ e[0], e == 12'h0}, {29'h0, quad});
      ask <= 1'h1;
      @(posedge clk);
      ask <= 1'h0;
      wait_rx(8'(i + 1));
      check("serial word", {20'h0, e}, {20'h0, rxWord});
    end
    // Requests queue behind a stalled receiver until the buffer refuses.
    grayOut <= 1'h0;
    lowTrue <= 1'h0;
    straps <= 3'h1;
    position <= 12'h3c1;
    serHold <= 1'h1;
    repeat (10) @(posedge clk);
    repeat (4) apb(1'h1, `APC_OFS_CTRL, 32'h7);
    apb(1'h0, `APC_OFS_REFUSED, 32'h0);
    check("refused count", 32'h1, rd);
    serHold <= 1'h0;
    wait_rx(8'h13);
    check("queued words", 32'h13, {24'h0, rxCount});
    check("queued value", 32'h3c1, {20'h0, rxWord});
    apb(1'h1, `APC_OFS_REFUSED, 32'h0);
    apb(1'h0, `APC_OFS_REFUSED, 32'h0);
    check("refused cleared", 32'h0, rd);
    // Quadrature output switched off by software.
    apb(1'h1, `APC_OFS_CTRL, 32'h1);
    repeat (4) @(posedge clk);
    check("quadrature off", 32'h0, {29'h0, quad});
    apb(1'h1, `APC_OFS_CTRL, 32'h5);
    // Family strap installed: no absolute mode and no transfer.
    straps <= 3'h5;
    repeat (10) @(posedge clk);
    check("absolute mode", 32'h0, {31'h0, absMode});
    ask <= 1'h1;
    @(posedge clk);
    ask <= 1'h0;
    repeat (200) @(posedge clk);
    check("no transfer", 32'h13, {24'h0, rxCount});
    give_verdict();
  end
endmodule : apc_conditioner_tb
